//--- verilog/umf_modem_flow.sv
// Purpose: Modem status, scratch, flow thresholds, trigger levels and baud divisor of one UART channel.
// Assumes: Fifo counts, transmitter busy and idle timeout come from logic on core_clk.
// Notes: Modem pins are asynchronous and pass a three flop filter.
`timescale 1ns/1ns
module umf_modem_flow (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire umf_pkg::umf_bus_req_t bus_req,
	output logic [7:0] rdata,
	input wire umf_pkg::umf_modem_pins_t modem_pins,
	input wire logic [6:0] rx_fifo_count,
	input wire logic [6:0] tx_fifo_free,
	input wire logic tx_char_busy,
	input wire logic rx_idle_timeout,
	output logic rts_n,
	output logic dtr_n,
	output logic tx_halt,
	output logic send_xoff,
	output logic send_xon,
	output umf_pkg::umf_divisor_t baud_divisor,
	output logic modem_irq,
	output logic tx_ready_irq,
	output logic rx_ready_irq,
	output logic rx_timeout_irq
);
	logic [7:0] line_control;
	logic [7:0] modem_control;
	logic [7:0] enhanced_feature_control;
	logic [7:0] interrupt_enable;
	logic [7:0] fifo_control;
	logic [7:0] scratch_pad;
	logic [7:0] flow_threshold;
	logic [7:0] fifo_trigger_levels;
	logic [7:0] divisor_low;
	logic [7:0] divisor_high;
	logic [7:0] divisor_fraction;
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [3:0] sync3;
	logic [3:0] pin_level;
	logic [3:0] status_prev;
	logic [3:0] status_now;
	logic [3:0] delta;
	logic [3:0] next_delta_set;
	logic [7:0] modem_status;
	logic [7:0] next_rdata;
	logic enhance;
	logic efr_sel;
	logic div_sel;
	logic threshold_sel;
	logic fifo_rdy_sel;
	logic trigger_sel;
	logic status_read;
	logic [6:0] halt_level;
	logic [6:0] resume_level;
	logic [6:0] tx_trigger;
	logic [6:0] rx_trigger;
	logic [7:0] fifo_ready;
	umf_pkg::umf_flow_state_t flow_state;
	umf_pkg::umf_flow_state_t next_flow_state;

	function automatic logic [6:0] umf_level(input logic [3:0] nib, input logic [1:0] sel, input logic is_rx);
		logic [6:0] fallback;
		fallback = umf_pkg::LEVEL_ZERO;
		unique case (sel)
			2'b00: fallback = is_rx ? umf_pkg::RX_LEVEL_FCR0 : umf_pkg::TX_LEVEL_FCR0;
			2'b01: fallback = is_rx ? umf_pkg::RX_LEVEL_FCR1 : umf_pkg::TX_LEVEL_FCR1;
			2'b10: fallback = is_rx ? umf_pkg::RX_LEVEL_FCR2 : umf_pkg::TX_LEVEL_FCR2;
			2'b11: fallback = is_rx ? umf_pkg::RX_LEVEL_FCR3 : umf_pkg::TX_LEVEL_FCR3;
		endcase
		return (nib != 4'h0) ? {1'b0, nib, 2'b00} : fallback;
	endfunction

	// Address decode of the shared offsets.
	assign enhance = enhanced_feature_control[umf_pkg::EFR_ENHANCE_BIT];
	assign efr_sel = (line_control == umf_pkg::LCR_ENHANCED_KEY);
	assign div_sel = line_control[umf_pkg::LCR_DIVISOR_BIT] && !efr_sel;
	assign threshold_sel = enhance && modem_control[umf_pkg::MCR_ACCESS_BIT];
	assign fifo_rdy_sel = !modem_control[umf_pkg::MCR_LOOP_BIT] && modem_control[umf_pkg::MCR_OUT1_BIT];
	assign trigger_sel = threshold_sel && !fifo_rdy_sel;
	assign status_read = bus_req.rd && (bus_req.addr == umf_pkg::ADDR_MODEM_STATUS) && !threshold_sel;

	// Three flop filter on the modem pins; the second and third flops must agree.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					sync1[gi] <= 1'b1;
					sync2[gi] <= 1'b1;
					sync3[gi] <= 1'b1;
					pin_level[gi] <= 1'b1;
				end else begin
					sync1[gi] <= modem_pins[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
					if (sync2[gi] == sync3[gi]) begin
						pin_level[gi] <= sync3[gi];
					end
				end
			end
		end
	endgenerate

	// Live status: inverted pins, or modem control bits in loopback.
	always_comb begin
		if (modem_control[umf_pkg::MCR_LOOP_BIT]) begin
			status_now = {modem_control[umf_pkg::MCR_OUT2_BIT], modem_control[umf_pkg::MCR_OUT1_BIT],
				modem_control[umf_pkg::MCR_DTR_BIT], modem_control[umf_pkg::MCR_RTS_BIT]};
		end else begin
			status_now = ~pin_level;
		end
	end

	// Delta events; ring only on input rising, which is status falling.
	always_comb begin
		next_delta_set[0] = status_now[0] ^ status_prev[0];
		next_delta_set[1] = status_now[1] ^ status_prev[1];
		next_delta_set[2] = status_prev[2] && !status_now[2];
		next_delta_set[3] = status_now[3] ^ status_prev[3];
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			status_prev <= 4'h0;
		end else begin
			status_prev <= status_now;
		end
	end

	// A read clears the flags, but a change in the same cycle still sets.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			delta <= 4'h0;
		end else begin
			delta <= (status_read ? 4'h0 : delta) | next_delta_set;
		end
	end

	assign modem_status = {status_now, delta};

	// Register writes.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			line_control <= umf_pkg::ZERO_RESET;
			modem_control <= umf_pkg::ZERO_RESET;
			enhanced_feature_control <= umf_pkg::ZERO_RESET;
			interrupt_enable <= umf_pkg::ZERO_RESET;
			fifo_control <= umf_pkg::ZERO_RESET;
			divisor_low <= umf_pkg::ZERO_RESET;
			divisor_high <= umf_pkg::ZERO_RESET;
			divisor_fraction <= umf_pkg::ZERO_RESET;
		end else if (bus_req.wr) begin
			unique case (bus_req.addr)
				umf_pkg::ADDR_DATA_DIV_LOW: begin
					if (div_sel) begin
						divisor_low <= bus_req.wdata;
					end
				end
				umf_pkg::ADDR_IER_DIV_HIGH: begin
					if (div_sel) begin
						divisor_high <= bus_req.wdata;
					end else if (!efr_sel) begin
						interrupt_enable[3:0] <= bus_req.wdata[3:0];
						if (enhance) begin
							interrupt_enable[7:4] <= bus_req.wdata[7:4];
						end
					end
				end
				umf_pkg::ADDR_FCR_EFR_FRAC: begin
					if (efr_sel) begin
						enhanced_feature_control <= bus_req.wdata;
					end else if (div_sel) begin
						if (enhance) begin
							divisor_fraction <= bus_req.wdata;
						end
					end else begin
						fifo_control[7:6] <= bus_req.wdata[7:6];
						fifo_control[3:0] <= bus_req.wdata[3:0];
						if (enhance) begin
							fifo_control[5:4] <= bus_req.wdata[5:4];
						end
					end
				end
				umf_pkg::ADDR_LINE_CONTROL: begin
					line_control <= bus_req.wdata;
				end
				umf_pkg::ADDR_MODEM_CONTROL: begin
					modem_control[4:0] <= bus_req.wdata[4:0];
					if (enhance) begin
						modem_control[7:5] <= bus_req.wdata[7:5];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Scratch, thresholds and triggers; the scratch keeps its value except on writes.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			scratch_pad <= umf_pkg::SCRATCH_RESET;
			flow_threshold <= umf_pkg::ZERO_RESET;
			fifo_trigger_levels <= umf_pkg::ZERO_RESET;
		end else if (bus_req.wr && !efr_sel) begin
			if (bus_req.addr == umf_pkg::ADDR_MODEM_STATUS && threshold_sel) begin
				flow_threshold <= bus_req.wdata;
			end
			if (bus_req.addr == umf_pkg::ADDR_SCRATCH) begin
				if (trigger_sel) begin
					fifo_trigger_levels <= bus_req.wdata;
				end else if (!fifo_rdy_sel) begin
					scratch_pad <= bus_req.wdata;
				end
			end
		end
	end

	// Register reads, answered in the cycle after the strobe.
	always_comb begin
		next_rdata = umf_pkg::ZERO_RESET;
		unique case (bus_req.addr)
			umf_pkg::ADDR_DATA_DIV_LOW: next_rdata = div_sel ? divisor_low : umf_pkg::ZERO_RESET;
			umf_pkg::ADDR_IER_DIV_HIGH: next_rdata = div_sel ? divisor_high : interrupt_enable;
			umf_pkg::ADDR_FCR_EFR_FRAC: begin
				if (efr_sel) begin
					next_rdata = enhanced_feature_control;
				end else if (div_sel && enhance) begin
					next_rdata = divisor_fraction;
				end
			end
			umf_pkg::ADDR_LINE_CONTROL: next_rdata = line_control;
			umf_pkg::ADDR_MODEM_CONTROL: next_rdata = modem_control;
			umf_pkg::ADDR_MODEM_STATUS: next_rdata = threshold_sel ? flow_threshold : modem_status;
			umf_pkg::ADDR_SCRATCH: begin
				if (fifo_rdy_sel) begin
					next_rdata = fifo_ready;
				end else if (trigger_sel) begin
					next_rdata = fifo_trigger_levels;
				end else begin
					next_rdata = scratch_pad;
				end
			end
			default: next_rdata = umf_pkg::ZERO_RESET;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= umf_pkg::ZERO_RESET;
		end else begin
			rdata <= bus_req.rd ? next_rdata : umf_pkg::ZERO_RESET;
		end
	end

	// Receive flow control with halt and resume thresholds.
	assign halt_level = {1'b0, flow_threshold[3:0], 2'b00};
	assign resume_level = {1'b0, flow_threshold[7:4], 2'b00};

	always_comb begin
		next_flow_state = flow_state;
		unique case (flow_state)
			umf_pkg::UMF_FLOW_RUN: begin
				if (rx_fifo_count >= halt_level) begin
					next_flow_state = umf_pkg::UMF_FLOW_HALT;
				end
			end
			umf_pkg::UMF_FLOW_HALT: begin
				if (rx_fifo_count <= resume_level) begin
					next_flow_state = umf_pkg::UMF_FLOW_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			flow_state <= umf_pkg::UMF_FLOW_RUN;
			send_xoff <= 1'b0;
			send_xon <= 1'b0;
		end else begin
			flow_state <= next_flow_state;
			send_xoff <= (|enhanced_feature_control[3:2]) && flow_state == umf_pkg::UMF_FLOW_RUN
				&& next_flow_state == umf_pkg::UMF_FLOW_HALT;
			send_xon <= (|enhanced_feature_control[3:2]) && flow_state == umf_pkg::UMF_FLOW_HALT
				&& next_flow_state == umf_pkg::UMF_FLOW_RUN;
		end
	end

	// Modem outputs; loopback holds them inactive.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
		end else begin
			rts_n <= modem_control[umf_pkg::MCR_LOOP_BIT] || !modem_control[umf_pkg::MCR_RTS_BIT]
				|| (enhanced_feature_control[umf_pkg::EFR_AUTO_RTS_BIT]
				&& flow_state == umf_pkg::UMF_FLOW_HALT);
			dtr_n <= modem_control[umf_pkg::MCR_LOOP_BIT] || !modem_control[umf_pkg::MCR_DTR_BIT];
		end
	end

	// Transmit halt changes only between characters.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_halt <= 1'b0;
		end else if (!tx_char_busy) begin
			tx_halt <= enhanced_feature_control[umf_pkg::EFR_AUTO_CTS_BIT] && !status_now[0];
		end
	end

	// Trigger levels and interrupts.
	assign tx_trigger = umf_level(fifo_trigger_levels[3:0], fifo_control[5:4], 1'b0);
	assign rx_trigger = umf_level(fifo_trigger_levels[7:4], fifo_control[7:6], 1'b1);
	assign fifo_ready = {6'h00, rx_fifo_count >= rx_trigger, tx_fifo_free >= tx_trigger};

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			modem_irq <= 1'b0;
			tx_ready_irq <= 1'b0;
			rx_ready_irq <= 1'b0;
			rx_timeout_irq <= 1'b0;
		end else begin
			modem_irq <= (|delta) && interrupt_enable[umf_pkg::IER_MODEM_BIT];
			tx_ready_irq <= tx_fifo_free >= tx_trigger;
			rx_ready_irq <= rx_fifo_count >= rx_trigger;
			rx_timeout_irq <= (rx_fifo_count != 7'h00) && rx_idle_timeout;
		end
	end

	assign baud_divisor = {divisor_high, divisor_low, divisor_fraction[3:0]};

	chk_modem_irq_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
		##1 modem_irq == $past((|delta) && interrupt_enable[umf_pkg::IER_MODEM_BIT]))
		else $error("modem interrupt does not follow flags and enable");
	chk_ring_fall_ignored: assert property (@(posedge core_clk) disable iff (!rst_b)
		(!status_prev[2] && status_now[2] && !delta[2]) |=> !delta[2])
		else $error("ring flag set on falling ring input");
	chk_cts_change_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
		(status_now[0] != status_prev[0]) |=> delta[0])
		else $error("clear to send change not flagged");
	chk_status_read_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
		(status_read && next_delta_set == 4'h0) |=> delta == 4'h0)
		else $error("status read did not clear flags");
	chk_loop_status_bits: assert property (@(posedge core_clk) disable iff (!rst_b)
		modem_control[umf_pkg::MCR_LOOP_BIT] |-> modem_status[4] == modem_control[umf_pkg::MCR_RTS_BIT])
		else $error("loopback status bit does not track request to send");
	chk_scratch_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		!(bus_req.wr && bus_req.addr == umf_pkg::ADDR_SCRATCH) |=> scratch_pad == $past(scratch_pad))
		else $error("scratch changed without a write");
	chk_halt_threshold: assert property (@(posedge core_clk) disable iff (!rst_b)
		(flow_state == umf_pkg::UMF_FLOW_RUN && rx_fifo_count >= halt_level) |=> flow_state == umf_pkg::UMF_FLOW_HALT)
		else $error("flow not halted at halt level");
	chk_resume_threshold: assert property (@(posedge core_clk) disable iff (!rst_b)
		(flow_state == umf_pkg::UMF_FLOW_HALT && rx_fifo_count <= resume_level) |=> flow_state == umf_pkg::UMF_FLOW_RUN)
		else $error("flow not resumed at resume level");
	chk_cts_halt_wait: assert property (@(posedge core_clk) disable iff (!rst_b)
		tx_char_busy |=> $stable(tx_halt))
		else $error("transmit halt changed mid character");
	chk_timeout_irq: assert property (@(posedge core_clk) disable iff (!rst_b)
		(rx_idle_timeout && rx_fifo_count != 7'h00) |=> rx_timeout_irq)
		else $error("receive timeout interrupt missing");
	chk_fraction_guard: assert property (@(posedge core_clk) disable iff (!rst_b)
		!enhance |=> $stable(divisor_fraction))
		else $error("fraction divisor written without enhance");
endmodule

//--- inc/umf_pkg.sv
// Purpose: Constants and types for the modem status, flow threshold and divisor register block.
// Assumes: One UART channel, one clock, register port with read data one cycle after the strobe.
// Notes: Contract
// Contract
// - Delta bits 0, 1, 3 set on any change of CTS, DSR, CD.
// - Delta bit 2 sets only when ring input rises, never on its fall.
// - Any set delta flag raises modem interrupt when interrupt enable bit 3 set.
// - Auto CTS: high CTS halts transmitter after current character; low resumes.
// - Status bit 4 is inverted CTS, or modem control RTS bit in loopback.
// - Status bit 5 is inverted DSR, or modem control DTR bit in loopback.
// - Status bit 6 is inverted ring input, or modem control bit 2 in loopback.
// - Status bit 7 is inverted carrier detect, or modem control bit 3 in loopback.
// - Scratch register holds host writes, resets to all ones.
// - Flow threshold replaces modem status only with modem control bit 6 and enhance.
// - Halt level is low nibble times four; count at or above halts flow.
// - Resume level is high nibble times four; count at or below resumes flow.
// - Trigger register replaces scratch under select conditions; writes need enhance bit.
// - Nonzero low trigger nibble times four is transmit trigger; zero uses fifo control.
// - Nonzero high trigger nibble times four is receive trigger; zero uses fifo control.
// - Receive timeout interrupt when fifo holds a byte and input idled long.
// - Divisor is high and low bytes plus fraction nibble over sixteen.
// - Fraction divisor register reachable only while enhance bit is set.
// - Offset seven shows scratch, trigger or fifo ready by select bits.
// - Line control bit 7 selects divisor registers over data registers.
package umf_pkg;
	localparam logic [2:0] ADDR_DATA_DIV_LOW = 3'h0;
	localparam logic [2:0] ADDR_IER_DIV_HIGH = 3'h1;
	localparam logic [2:0] ADDR_FCR_EFR_FRAC = 3'h2;
	localparam logic [2:0] ADDR_LINE_CONTROL = 3'h3;
	localparam logic [2:0] ADDR_MODEM_CONTROL = 3'h4;
	localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
	localparam logic [2:0] ADDR_SCRATCH = 3'h7;
	localparam logic [7:0] LCR_ENHANCED_KEY = 8'hBF;
	localparam int LCR_DIVISOR_BIT = 7;
	localparam int EFR_ENHANCE_BIT = 4;
	localparam int EFR_AUTO_RTS_BIT = 6;
	localparam int EFR_AUTO_CTS_BIT = 7;
	localparam int MCR_DTR_BIT = 0;
	localparam int MCR_RTS_BIT = 1;
	localparam int MCR_OUT1_BIT = 2;
	localparam int MCR_OUT2_BIT = 3;
	localparam int MCR_LOOP_BIT = 4;
	localparam int MCR_ACCESS_BIT = 6;
	localparam int IER_MODEM_BIT = 3;
	localparam logic [7:0] SCRATCH_RESET = 8'hFF;
	localparam logic [7:0] ZERO_RESET = 8'h00;
	localparam logic [6:0] LEVEL_ZERO = 7'h00;
	localparam logic [6:0] TX_LEVEL_FCR0 = 7'h08;
	localparam logic [6:0] TX_LEVEL_FCR1 = 7'h10;
	localparam logic [6:0] TX_LEVEL_FCR2 = 7'h20;
	localparam logic [6:0] TX_LEVEL_FCR3 = 7'h30;
	localparam logic [6:0] RX_LEVEL_FCR0 = 7'h08;
	localparam logic [6:0] RX_LEVEL_FCR1 = 7'h10;
	localparam logic [6:0] RX_LEVEL_FCR2 = 7'h20;
	localparam logic [6:0] RX_LEVEL_FCR3 = 7'h30;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} umf_bus_req_t;

	typedef struct packed {
		logic cd_n;
		logic ri_n;
		logic dsr_n;
		logic cts_n;
	} umf_modem_pins_t;

	typedef struct packed {
		logic [15:0] whole;
		logic [3:0] fraction;
	} umf_divisor_t;

	typedef enum logic {
		UMF_FLOW_RUN = 1'b0,
		UMF_FLOW_HALT = 1'b1
	} umf_flow_state_t;
endpackage

//--- testbench/umf_modem_partner.sv
// Purpose: Remote modem that drives the handshake inputs of the block.
// Assumes: The bench says which pin levels it wants and how many cycles the modem takes.
// Notes: Pins are driven levels with no release, so no idle pattern is needed.
`timescale 1ns/1ns
module umf_modem_partner (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire umf_pkg::umf_modem_pins_t want,
	input wire logic [3:0] lag,
	output umf_pkg::umf_modem_pins_t modem_pins
);
	logic [3:0] wait_cnt;

	// A slow modem holds the old levels for lag cycles before it follows the request.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			modem_pins <= 4'hF;
			wait_cnt <= 4'h0;
		end else if (want !== modem_pins && wait_cnt < lag) begin
			wait_cnt <= wait_cnt + 4'h1;
		end else begin
			modem_pins <= want;
			wait_cnt <= 4'h0;
		end
	end
endmodule

//--- testbench/umf_modem_flow_bench.sv
// Purpose: Self-checking bench for the modem status and flow threshold block.
// Assumes: Register reads are noted in a queue and checked in the cycle after the read strobe.
// Notes: Level outputs are checked at the falling edge once they have settled.
`timescale 1ns/1ns
module umf_modem_flow_bench;
	logic core_clk = 0;
	logic rst_b = 0;
	umf_pkg::umf_bus_req_t bus_req = '0;
	umf_pkg::umf_modem_pins_t want = 4'hF;
	umf_pkg::umf_modem_pins_t modem_pins;
	logic [3:0] lag = 4'h0;
	logic [6:0] rx_fifo_count = 7'h00;
	logic [6:0] tx_fifo_free = 7'h00;
	logic tx_char_busy = 0;
	logic rx_idle_timeout = 0;
	logic [7:0] rdata;
	logic rts_n, dtr_n, tx_halt, send_xoff, send_xon, modem_irq, tx_ready_irq, rx_ready_irq, rx_timeout_irq;
	umf_pkg::umf_divisor_t baud_divisor;
	int err_count = 0;
	int n_compared = 0;
	int n_xoff = 0;
	int n_xon = 0;
	int xoff_base = 0;
	int xon_base = 0;
	logic [31:0] seed = 32'hf6e7_a770;
	logic [7:0] exp_q[$];
	logic [7:0] mask_q[$];
	logic rd_seen = 0;
	logic [7:0] lo, hi, spad, dlt;
	logic [6:0] lvl[4] = '{7'h08, 7'h10, 7'h20, 7'h30};

	umf_modem_partner modem (.core_clk(core_clk), .rst_b(rst_b), .want(want), .lag(lag), .modem_pins(modem_pins));
	umf_modem_flow dut (.core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req), .rdata(rdata),
		.modem_pins(modem_pins), .rx_fifo_count(rx_fifo_count), .tx_fifo_free(tx_fifo_free),
		.tx_char_busy(tx_char_busy), .rx_idle_timeout(rx_idle_timeout), .rts_n(rts_n), .dtr_n(dtr_n),
		.tx_halt(tx_halt), .send_xoff(send_xoff), .send_xon(send_xon), .baud_divisor(baud_divisor),
		.modem_irq(modem_irq), .tx_ready_irq(tx_ready_irq), .rx_ready_irq(rx_ready_irq),
		.rx_timeout_irq(rx_timeout_irq));

	always #10 core_clk = ~core_clk;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task end_sim;
		if (err_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic rnd(output logic [7:0] r);
		seed = lfsr(seed);
		r = seed[7:0];
	endtask

	task automatic bus(input logic [2:0] a, input logic [7:0] d, input logic w);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: d, wr: w, rd: ~w};
		@(posedge core_clk);
		bus_req <= '0;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		bus(a, d, 1'b1);
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
		exp_q.push_back(e);
		mask_q.push_back(m);
		bus(a, 8'h00, 1'b0);
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask

	always @(posedge core_clk) begin
		rd_seen <= bus_req.rd;
		if (send_xoff === 1'b1)
			n_xoff++;
		if (send_xon === 1'b1)
			n_xon++;
	end

	always @(negedge core_clk) begin
		if (rd_seen) begin
			check("rdata", rdata & mask_q[0], exp_q[0] & mask_q[0]);
			void'(exp_q.pop_front());
			void'(mask_q.pop_front());
		end
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		end_sim;
	end

	initial begin
		repeat (6) @(posedge core_clk);
		rst_b <= 1;
		rd(3'h7, 8'hFF, 8'hFF);
		rnd(spad);
		wr(3'h7, spad);
		rd(3'h7, spad, 8'hFF);
		wr(3'h1, 8'h08);
		rd(3'h6, 8'h00, 8'h00);
		for (int i = 0; i < 4; i++) begin
			for (int up = 0; up < 2; up++) begin
				@(posedge core_clk);
				lag <= 4'(i);
				want[i] <= up[0];
				wait_clk(8 + i);
				dlt = (up == 1 || i != 2) ? 8'h01 << i : 8'h00;
				check("modem_irq", modem_irq, dlt != 0);
				rd(3'h6, {~want, 4'h0} | dlt, 8'hFF);
				rd(3'h6, {~want, 4'h0}, 8'hFF);
				wait_clk(1);
				check("modem_irq", modem_irq, 0);
			end
		end
		wr(3'h4, 8'h1F);
		wait_clk(8);
		rd(3'h6, 8'hFB, 8'hFF);
		wr(3'h4, 8'h15);
		wait_clk(8);
		rd(3'h6, 8'h69, 8'hFF);
		wr(3'h4, 8'h03);
		wait_clk(8);
		check("dtr_n", dtr_n, 0);
		rd(3'h6, 8'h00, 8'h00);
		@(posedge core_clk);
		tx_char_busy <= 1;
		wr(3'h3, 8'hBF);
		wr(3'h2, 8'hD8);
		wr(3'h3, 8'h00);
		wait_clk(2);
		check("tx_halt", tx_halt, 0);
		@(posedge core_clk);
		tx_char_busy <= 0;
		wait_clk(2);
		check("tx_halt", tx_halt, 1);
		@(posedge core_clk);
		want[0] <= 0;
		wait_clk(10);
		check("tx_halt", tx_halt, 0);
		wr(3'h4, 8'h42);
		wr(3'h6, 8'h24);
		rd(3'h6, 8'h24, 8'hFF);
		wr(3'h7, 8'h32);
		rd(3'h7, 8'h32, 8'hFF);
		xoff_base = n_xoff;
		xon_base = n_xon;
		for (int k = 0; k < 4; k++) begin
			@(posedge core_clk);
			rx_fifo_count <= k[0] ? 7'(16 - k / 2 * 8) : 7'(15 - k / 2 * 6);
			wait_clk(4);
			check("rts_n", rts_n, k != 0 && k != 3);
		end
		check("xoff", n_xoff - xoff_base, 1);
		check("xon", n_xon - xon_base, 1);
		for (int k = 0; k < 2; k++) begin
			@(posedge core_clk);
			rx_fifo_count <= 7'(11 + k);
			tx_fifo_free <= 7'(7 + k);
			wait_clk(3);
			check("rx_ready_irq", rx_ready_irq, k);
			check("tx_ready_irq", tx_ready_irq, k);
		end
		wr(3'h7, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(3'h2, {2'(c), 2'(c), 4'h0});
			for (int k = 0; k < 2; k++) begin
				@(posedge core_clk);
				rx_fifo_count <= lvl[c] - 7'(1 - k);
				tx_fifo_free <= lvl[c] - 7'(1 - k);
				wait_clk(3);
				check("rx_ready_irq", rx_ready_irq, k);
				check("tx_ready_irq", tx_ready_irq, k);
			end
		end
		wr(3'h4, 8'h04);
		wr(3'h7, 8'h5A);
		rd(3'h7, 8'h03, 8'hFF);
		wr(3'h4, 8'h42);
		for (int k = 0; k < 2; k++) begin
			@(posedge core_clk);
			rx_fifo_count <= 7'(k);
			rx_idle_timeout <= 1;
			wait_clk(3);
			check("rx_timeout_irq", rx_timeout_irq, k);
		end
		rnd(lo);
		rnd(hi);
		wr(3'h3, 8'h80);
		wr(3'h0, lo);
		wr(3'h1, hi);
		wr(3'h2, 8'h0B);
		wait_clk(1);
		check("baud_divisor", baud_divisor, {hi, lo, 4'hB});
		rd(3'h0, lo, 8'hFF);
		rd(3'h1, hi, 8'hFF);
		wr(3'h3, 8'h00);
		rd(3'h1, 8'h08, 8'hFF);
		wr(3'h3, 8'hBF);
		wr(3'h2, 8'h00);
		wr(3'h3, 8'h80);
		wr(3'h2, 8'h05);
		wait_clk(1);
		check("fraction", baud_divisor.fraction, 4'hB);
		wr(3'h3, 8'h00);
		rd(3'h6, 8'h10, 8'hF0);
		rd(3'h7, spad, 8'hFF);
		rd(3'h5, 8'h00, 8'hFF);
		@(posedge core_clk);
		rst_b <= 0;
		repeat (6) @(posedge core_clk);
		rst_b <= 1;
		rd(3'h7, 8'hFF, 8'hFF);
		wait_clk(2);
		end_sim;
	end
endmodule
